// ==== common/tsig_pkg.sv ====
// Purpose: shared constants for the transmit robbed-bit signaling block
// Assumes: T1 framing, 24 channels, 8-bit microport data, MSB-first serial control stream
// Notes:   frame numbers are 1-based as counted within the superframe

package tsig_pkg;

    // ************************************************************
    // channel and word geometry
    // ************************************************************
    localparam int          NUM_CH       = 24;     // DS1 channels
    localparam int          CH_W         = 5;      // width of a channel index
    localparam int          LO_PAGE_CH   = 16;     // channels served by the first page
    localparam int          SLOT_W       = 8;      // bits per time slot and per register
    localparam int          SIG_W        = 4;      // A, B, C, D
    localparam int          NIB_HI_LSB   = 4;      // lowest bit of the upper nibble
    localparam int          BITCNT_W     = 3;      // bit counter inside a slot

    // ************************************************************
    // microport map
    // ************************************************************
    localparam logic [3:0]  PAGE_TX_LO   = 4'h5;   // channels 1 to 16
    localparam logic [3:0]  PAGE_TX_HI   = 4'h6;   // channels 17 to 24
    localparam logic [4:0]  ADDR_WIN_MSK = 5'h10;  // upper address bit selects the word block
    localparam logic [4:0]  ADDR_SIG_BASE = 5'h10; // first signaling word
    localparam logic [4:0]  ADDR_HI_LAST = 5'h17;  // last mapped word of the second page
    localparam logic [3:0]  SIG_RESET    = 4'h0;   // signaling words after reset

    // ************************************************************
    // signaling bit positions and robbed frames
    // ************************************************************
    localparam int          BIT_A        = 3;
    localparam int          BIT_B        = 2;
    localparam int          BIT_C        = 1;
    localparam int          BIT_D        = 0;
    localparam int          ROB_BIT      = 0;      // bit position 8 is the last bit sent, the LSB
    localparam logic [4:0]  FRM_A        = 5'h06;
    localparam logic [4:0]  FRM_B        = 5'h0C;
    localparam logic [4:0]  FRM_C        = 5'h12;
    localparam logic [4:0]  FRM_D        = 5'h18;

endpackage : tsig_pkg

// ==== rtl/tsig_cst_rx.sv ====
// Purpose: deserialise the serial control stream into one byte per active slot
// Assumes: data is a pin and is synchronised; tick and frame start come from local timing
// Notes:   tick and frame start are delayed two cycles to stay aligned with the synchronised data

`timescale 1ns/10ps

module tsig_cst_rx
    import tsig_pkg::*;
#(
    parameter int SLOTS = NUM_CH
) (
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic              serial_control_stream_in,
    input  wire logic              cst_frame_start,
    input  wire logic              cst_bit_tick,
    output logic                   slot_valid,
    output logic [CH_W-1:0]        slot_idx,
    output logic [SLOT_W-1:0]      slot_byte
);

    typedef enum logic [1:0] {
        TSIG_RX_IDLE   = 2'b01,
        TSIG_RX_ACTIVE = 2'b10
    } tsig_rx_state_t;

    tsig_rx_state_t         state_reg, state_next;
    logic                   sync1_reg, sync2_reg;
    logic [1:0]             tick_d_reg, fs_d_reg;
    logic [BITCNT_W-1:0]    bit_reg, bit_next;
    logic [CH_W-1:0]        slot_reg, slot_next;
    logic [SLOT_W-1:0]      shift_reg, shift_next;
    logic                   valid_reg, valid_next;
    logic [CH_W-1:0]        idx_reg, idx_next;
    logic [SLOT_W-1:0]      byte_reg, byte_next;

    // slot framing: every active slot yields one byte, trailing slots are skipped
    always_comb begin
        state_next = state_reg;
        bit_next   = bit_reg;
        slot_next  = slot_reg;
        shift_next = shift_reg;
        valid_next = 1'b0;
        idx_next   = idx_reg;
        byte_next  = byte_reg;
        if (tick_d_reg[1] && fs_d_reg[1]) begin
            state_next = TSIG_RX_ACTIVE;
            shift_next = {{(SLOT_W-1){1'b0}}, sync2_reg};
            bit_next   = BITCNT_W'(1);
            slot_next  = '0;
        end else if (tick_d_reg[1] && state_reg == TSIG_RX_ACTIVE) begin
            shift_next = {shift_reg[SLOT_W-2:0], sync2_reg};
            bit_next   = bit_reg + BITCNT_W'(1);
            if (bit_reg == BITCNT_W'(SLOT_W-1)) begin
                valid_next = 1'b1;
                idx_next   = slot_reg;
                byte_next  = shift_next;
                slot_next  = slot_reg + CH_W'(1);
                if (slot_reg == CH_W'(SLOTS-1)) begin
                    state_next = TSIG_RX_IDLE;
                end
            end
        end
    end

    // first sync stage feeds only the second
    always_ff @(posedge ref_clk) begin
        sync1_reg  <= serial_control_stream_in;
        sync2_reg  <= sync1_reg;
        tick_d_reg <= {tick_d_reg[0], cst_bit_tick};
        fs_d_reg   <= {fs_d_reg[0], cst_frame_start};
        if (srst) begin
            state_reg <= TSIG_RX_IDLE;
            bit_reg   <= '0;
            slot_reg  <= '0;
            shift_reg <= '0;
            valid_reg <= 1'b0;
            idx_reg   <= '0;
            byte_reg  <= '0;
        end else begin
            state_reg <= state_next;
            bit_reg   <= bit_next;
            slot_reg  <= slot_next;
            shift_reg <= shift_next;
            valid_reg <= valid_next;
            idx_reg   <= idx_next;
            byte_reg  <= byte_next;
        end
    end

    assign slot_valid = valid_reg;
    assign slot_idx   = idx_reg;
    assign slot_byte  = byte_reg;

    property p_slot_bound;
        @(posedge ref_clk) disable iff (srst)
        valid_reg |-> (idx_reg < CH_W'(SLOTS));
    endproperty
    a_slot_bound: assert property (p_slot_bound) else $error("slot index beyond active slots");

    property p_slot_spacing;
        @(posedge ref_clk) disable iff (srst)
        valid_reg |=> !valid_reg;
    endproperty
    a_slot_spacing: assert property (p_slot_spacing) else $error("slot bytes back to back");

endmodule : tsig_cst_rx

// ==== rtl/tsig_ins.sv ====
// Purpose: rob bit position 8 of one channel byte with its signaling bit
// Assumes: frame number counts 1..12 in D4 and 1..24 in ESF
// Notes:   purely combinational; the caller registers the result

`timescale 1ns/10ps

module tsig_ins
    import tsig_pkg::*;
(
    input  wire logic [SLOT_W-1:0] byte_in,
    input  wire logic [4:0]        frame_num,
    input  wire logic              esf_mode,
    input  wire logic              clear_channel,
    input  wire logic [SIG_W-1:0]  abcd,
    output logic      [SLOT_W-1:0] byte_out
);

    // a and b in both formats, c and d only in the 24-frame superframe
    always_comb begin
        byte_out = byte_in;
        if (!clear_channel) begin
            if (frame_num == FRM_A) begin
                byte_out[ROB_BIT] = abcd[BIT_A];
            end else if (frame_num == FRM_B) begin
                byte_out[ROB_BIT] = abcd[BIT_B];
            end else if (esf_mode && frame_num == FRM_C) begin
                byte_out[ROB_BIT] = abcd[BIT_C];
            end else if (esf_mode && frame_num == FRM_D) begin
                byte_out[ROB_BIT] = abcd[BIT_D];
            end
        end
    end

endmodule : tsig_ins

// ==== rtl/tsig_top.sv ====
// Purpose: transmit robbed-bit signaling insertion for a T1 framer
// Assumes: microport strobes, per-slot control bits and line timing are on ref_clk;
//          only the serial control stream data pin is asynchronous
// Notes:   new signaling takes effect only at a superframe boundary

`timescale 1ns/10ps

// How it works
// - signaling words at two pages, 24 channels
// - select high: take bits from host register
// - select low: take bits from serial stream
// - bit 3 is A, frame 6
// - bit 2 is B, frame 12
// - bit 1 is C, ESF frame 18 only
// - bit 0 is D, ESF frame 24 only
// - bits 7 to 4 unused, no effect
// - 24 stream slots, one byte each, sampled
// - nibble select high uses upper nibble
// - nibble select low uses lower nibble
// - ESF sends A, B, C, D in 6,12,18,24
// - D4 sends A, B; drops C, D
// - second page words 8 to 15 unmapped
// - clear channel suppresses robbed-bit insertion
// - source select is per-slot control bit 1
module tsig_top
    import tsig_pkg::*;
#(
    parameter int CHANNELS = NUM_CH
) (
    input  wire logic                ref_clk,
    input  wire logic                srst,
    input  wire logic                mp_cs,
    input  wire logic                mp_wr,
    input  wire logic                mp_rd,
    input  wire logic [3:0]          mp_page,
    input  wire logic [4:0]          mp_addr,
    input  wire logic [SLOT_W-1:0]   mp_wdata,
    output logic      [SLOT_W-1:0]   mp_rdata,
    input  wire logic [CHANNELS-1:0] sig_source_select,
    input  wire logic [CHANNELS-1:0] clear_channel_flag,
    input  wire logic                upper_nibble_select,
    input  wire logic                esf_mode,
    input  wire logic                serial_control_stream_in,
    input  wire logic                cst_frame_start,
    input  wire logic                cst_bit_tick,
    input  wire logic                tx_sf_start,
    input  wire logic                tx_byte_valid,
    input  wire logic [4:0]          tx_frame_num,
    input  wire logic [CH_W-1:0]     tx_chan,
    input  wire logic [SLOT_W-1:0]   tx_byte_in,
    output logic      [SLOT_W-1:0]   tx_byte_out,
    output logic                     tx_byte_out_valid
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [SIG_W-1:0]   sig_reg     [CHANNELS];   // host-written words
    logic [SIG_W-1:0]   sig_next    [CHANNELS];
    logic [SIG_W-1:0]   cst_nib_reg [CHANNELS];   // latest nibble from the stream
    logic [SIG_W-1:0]   cst_nib_next[CHANNELS];
    logic [SIG_W-1:0]   act_reg     [CHANNELS];   // bits in force this superframe
    logic [SIG_W-1:0]   act_next    [CHANNELS];
    logic [SLOT_W-1:0]  rdata_reg, rdata_next;
    logic [SLOT_W-1:0]  out_reg, out_next;
    logic               out_valid_reg, out_valid_next;

    logic               map_hit;
    logic [CH_W-1:0]    map_ch;
    logic               wr_req;
    logic               rd_req;
    logic               slot_valid;
    logic [CH_W-1:0]    slot_idx;
    logic [SLOT_W-1:0]  slot_byte;
    logic [SIG_W-1:0]   slot_nib;
    logic               chan_ok;
    logic [SIG_W-1:0]   sel_abcd;
    logic               sel_clear;
    logic [SLOT_W-1:0]  ins_byte;

    // ************************************************************
    // serial control stream
    // ************************************************************

    // one byte per active slot, slots past the channel count are ignored
    tsig_cst_rx #(
        .SLOTS                    (CHANNELS)
    ) u_cst_rx (
        .ref_clk                  (ref_clk),
        .srst                     (srst),
        .serial_control_stream_in (serial_control_stream_in),
        .cst_frame_start          (cst_frame_start),
        .cst_bit_tick             (cst_bit_tick),
        .slot_valid               (slot_valid),
        .slot_idx                 (slot_idx),
        .slot_byte                (slot_byte)
    );

    // nibble choice is global, not per channel
    always_comb begin
        if (upper_nibble_select) begin
            slot_nib = slot_byte[NIB_HI_LSB +: SIG_W];
        end else begin
            slot_nib = slot_byte[SIG_W-1:0];
        end
    end

    // ************************************************************
    // microport decode
    // ************************************************************

    // the second page maps only its first eight words; the rest hit nothing
    always_comb begin
        map_hit = 1'b0;
        map_ch  = '0;
        if ((mp_addr & ADDR_WIN_MSK) == ADDR_SIG_BASE) begin
            if (mp_page == PAGE_TX_LO) begin
                map_hit = 1'b1;
                map_ch  = {1'b0, mp_addr[3:0]};
            end else if (mp_page == PAGE_TX_HI && mp_addr <= ADDR_HI_LAST) begin
                map_hit = 1'b1;
                map_ch  = CH_W'(LO_PAGE_CH) + {2'b00, mp_addr[2:0]};
            end
        end
    end

    assign wr_req = mp_cs && mp_wr && map_hit;
    assign rd_req = mp_cs && mp_rd;

    // ************************************************************
    // per-channel state
    // ************************************************************

    // each channel keeps both sources ready; the choice is made at the boundary
    // so a change mid-superframe never splits A and B across two values
    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
        always_comb begin
            sig_next[g]     = sig_reg[g];
            cst_nib_next[g] = cst_nib_reg[g];
            act_next[g]     = act_reg[g];
            if (wr_req && map_ch == CH_W'(g)) begin
                sig_next[g] = mp_wdata[SIG_W-1:0];
            end
            if (slot_valid && slot_idx == CH_W'(g)) begin
                cst_nib_next[g] = slot_nib;
            end
            if (tx_sf_start) begin
                if (sig_source_select[g]) begin
                    act_next[g] = sig_reg[g];
                end else begin
                    act_next[g] = cst_nib_reg[g];
                end
            end
        end
    end

    // read returns the word, upper nibble zero; unmapped reads zero
    always_comb begin
        rdata_next = rdata_reg;
        if (rd_req) begin
            if (map_hit) begin
                rdata_next = {{(SLOT_W-SIG_W){1'b0}}, sig_reg[map_ch]};
            end else begin
                rdata_next = '0;
            end
        end
    end

    // ************************************************************
    // line side insertion
    // ************************************************************

    // out-of-range channel numbers pass untouched
    always_comb begin
        chan_ok   = (tx_chan < CH_W'(CHANNELS));
        sel_abcd  = '0;
        sel_clear = 1'b1;
        if (chan_ok) begin
            sel_abcd  = act_reg[tx_chan];
            sel_clear = clear_channel_flag[tx_chan];
        end
    end

    // one insertion path serves both sources, which keeps register and stream handling identical
    tsig_ins u_ins (
        .byte_in       (tx_byte_in),
        .frame_num     (tx_frame_num),
        .esf_mode      (esf_mode),
        .clear_channel (sel_clear),
        .abcd          (sel_abcd),
        .byte_out      (ins_byte)
    );

    // output byte holds between line strobes
    always_comb begin
        out_valid_next = tx_byte_valid;
        out_next       = out_reg;
        if (tx_byte_valid) begin
            out_next = ins_byte;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < CHANNELS; i++) begin
                sig_reg[i]     <= SIG_RESET;
                cst_nib_reg[i] <= SIG_RESET;
                act_reg[i]     <= SIG_RESET;
            end
            rdata_reg     <= '0;
            out_reg       <= '0;
            out_valid_reg <= 1'b0;
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                sig_reg[i]     <= sig_next[i];
                cst_nib_reg[i] <= cst_nib_next[i];
                act_reg[i]     <= act_next[i];
            end
            rdata_reg     <= rdata_next;
            out_reg       <= out_next;
            out_valid_reg <= out_valid_next;
        end
    end

    assign mp_rdata          = rdata_reg;
    assign tx_byte_out       = out_reg;
    assign tx_byte_out_valid = out_valid_reg;

    // ************************************************************
    // checks
    // ************************************************************

    property p_rob_a;
        @(posedge ref_clk) disable iff (srst)
        (tx_byte_valid && !sel_clear && tx_frame_num == FRM_A)
            |=> (tx_byte_out[ROB_BIT] == $past(sel_abcd[BIT_A])) && tx_byte_out_valid;
    endproperty
    a_rob_a: assert property (p_rob_a) else $error("bit A not robbed in frame 6");

    property p_rob_b;
        @(posedge ref_clk) disable iff (srst)
        (tx_byte_valid && !sel_clear && tx_frame_num == FRM_B)
            |=> tx_byte_out[ROB_BIT] == $past(sel_abcd[BIT_B]);
    endproperty
    a_rob_b: assert property (p_rob_b) else $error("bit B not robbed in frame 12");

    property p_rob_c_esf;
        @(posedge ref_clk) disable iff (srst)
        (tx_byte_valid && !sel_clear && esf_mode && tx_frame_num == FRM_C)
            |=> tx_byte_out[ROB_BIT] == $past(sel_abcd[BIT_C]);
    endproperty
    a_rob_c_esf: assert property (p_rob_c_esf) else $error("bit C not robbed in ESF frame 18");

    property p_rob_d_esf;
        @(posedge ref_clk) disable iff (srst)
        (tx_byte_valid && !sel_clear && esf_mode && tx_frame_num == FRM_D)
            |=> tx_byte_out[ROB_BIT] == $past(sel_abcd[BIT_D]);
    endproperty
    a_rob_d_esf: assert property (p_rob_d_esf) else $error("bit D not robbed in ESF frame 24");

    property p_d4_no_c;
        @(posedge ref_clk) disable iff (srst)
        (tx_byte_valid && !esf_mode && tx_frame_num == FRM_C)
            |=> tx_byte_out == $past(tx_byte_in);
    endproperty
    a_d4_no_c: assert property (p_d4_no_c) else $error("D4 byte altered in frame 18");

    property p_clear_pass;
        @(posedge ref_clk) disable iff (srst)
        (tx_byte_valid && sel_clear) |=> tx_byte_out == $past(tx_byte_in);
    endproperty
    a_clear_pass: assert property (p_clear_pass) else $error("clear channel byte altered");

    property p_upper_zero;
        @(posedge ref_clk) disable iff (srst)
        rd_req |=> mp_rdata[SLOT_W-1:SIG_W] == '0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("unused bits read nonzero");

    property p_unmapped_zero;
        @(posedge ref_clk) disable iff (srst)
        (rd_req && mp_page == PAGE_TX_HI && mp_addr > ADDR_HI_LAST) |=> mp_rdata == '0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped word read nonzero");

    property p_hold_sf;
        @(posedge ref_clk) disable iff (srst)
        !tx_sf_start |=> act_reg[0] == $past(act_reg[0]);
    endproperty
    a_hold_sf: assert property (p_hold_sf) else $error("signaling changed mid superframe");

    property p_src_reg;
        @(posedge ref_clk) disable iff (srst)
        (tx_sf_start && sig_source_select[0]) |=> act_reg[0] == $past(sig_reg[0]);
    endproperty
    a_src_reg: assert property (p_src_reg) else $error("register source not taken");

    property p_src_cst;
        @(posedge ref_clk) disable iff (srst)
        (tx_sf_start && !sig_source_select[0]) |=> act_reg[0] == $past(cst_nib_reg[0]);
    endproperty
    a_src_cst: assert property (p_src_cst) else $error("stream source not taken");

endmodule : tsig_top

// ==== testbench/tsig_cst_src.sv ====
// Purpose: backplane source of the serial control stream, one frame per go pulse
// Assumes: ticks six cycles apart, each bit held from two cycles before to three after its tick
// Notes:   the pin toggles outside a frame so a stale bit never passes as valid

`timescale 1ns/10ps

module tsig_cst_src
    import tsig_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                go,
    input  wire logic [NUM_CH*8-1:0] bytes,
    output logic                     frame_start,
    output logic                     bit_tick,
    output logic                     data
);
    int unsigned cnt = 2000;
    logic        tgl = 1'b0;

    // frame position counter, parked past the end between frames
    always @(posedge ref_clk) begin
        tgl <= ~tgl;
        if (go) begin
            cnt <= 0;
        end else if (cnt < 2000) begin
            cnt <= cnt + 1;
        end
    end

    // one byte per slot, slot n feeds channel n+1, msb first
    always_comb begin
        frame_start = (cnt == 2);
        bit_tick    = (cnt < 1152) && (cnt % 6 == 2);
        data        = (cnt < 1152) ? bytes[(cnt / 48) * 8 + 7 - (cnt / 6) % 8] : tgl;
    end
endmodule : tsig_cst_src

// ==== testbench/tsig_top_bench.sv ====
// Purpose: self-checking bench for transmit robbed-bit signaling
// Assumes: the stream source model drives the backplane pins
// Notes:   drivers queue expected bytes; a monitor pops and compares them

`timescale 1ns/10ps

module tsig_top_bench;
    import tsig_pkg::*;
    logic ref_clk = 0, srst = 1, mp_cs = 0, mp_wr = 0, mp_rd = 0, esf = 0, uns = 0, go = 0, sfs = 0, bv = 0;
    logic rd_q = 0, bov, fs, tk, sd;
    logic [3:0] pg = 0;
    logic [4:0] ad = 0, fn = 1, ch = 0;
    logic [7:0] wd = 0, bi = 0, w, rdata, bo;
    logic [23:0] sel = 0, cc = 0;
    logic [191:0] sbytes = 0;
    logic [3:0] regs[24], act[24];
    logic [7:0] eq_tx[$], eq_rd[$];
    logic [31:0] seed = 79;
    int err_total = 0, checks = 0;

    tsig_top dut_u (.ref_clk(ref_clk), .srst(srst), .mp_cs(mp_cs), .mp_wr(mp_wr), .mp_rd(mp_rd),
        .mp_page(pg), .mp_addr(ad), .mp_wdata(wd), .mp_rdata(rdata), .sig_source_select(sel),
        .clear_channel_flag(cc), .upper_nibble_select(uns), .esf_mode(esf), .serial_control_stream_in(sd),
        .cst_frame_start(fs), .cst_bit_tick(tk), .tx_sf_start(sfs), .tx_byte_valid(bv), .tx_frame_num(fn),
        .tx_chan(ch), .tx_byte_in(bi), .tx_byte_out(bo), .tx_byte_out_valid(bov));
    tsig_cst_src src_u (.ref_clk(ref_clk), .go(go), .bytes(sbytes), .frame_start(fs), .bit_tick(tk), .data(sd));

    always #5 ref_clk = ~ref_clk;

    // ****************************************
    // drivers
    // ****************************************
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // inputs always move one nanosecond after the rising edge
    task tick();
        @(posedge ref_clk);
        #1;
    endtask : tick

    // one microport cycle; for a read, d is the expected data
    task acc(input logic wr, input logic [3:0] p, input logic [4:0] a, input logic [7:0] d);
        tick();
        {mp_cs, mp_wr, mp_rd, pg, ad, wd} = {1'b1, wr, !wr, p, a, d};
        if (!wr) eq_rd.push_back(d);
        tick();
        {mp_cs, mp_wr, mp_rd} = 3'b000;
    endtask : acc

    // superframe boundary: active nibbles follow the sources present on the pulse
    task sf();
        tick();
        sfs = 1;
        for (int c = 0; c < 24; c++) begin
            act[c] = sel[c] ? regs[c] : (uns ? sbytes[c*8+4 +: 4] : sbytes[c*8 +: 4]);
        end
        tick();
        sfs = 0;
    endtask : sf

    function logic rob(input logic [4:0] f, input logic [3:0] s, input logic b0);
        case (f)
            FRM_A: return s[BIT_A];
            FRM_B: return s[BIT_B];
            FRM_C: return esf ? s[BIT_C] : b0;
            FRM_D: return esf ? s[BIT_D] : b0;
            default: return b0;
        endcase
    endfunction : rob

    // back-to-back bytes of every channel, plus one out-of-range channel, in a plain frame and each robbed frame;
    // D4 also gets frames 18 and 24 so that dropping C and D is exercised
    task sweep();
        logic [4:0] fl[5];
        logic [7:0] b;
        fl = '{5'h05, FRM_A, FRM_B, FRM_C, FRM_D};
        foreach (fl[i]) begin
            for (int c = 0; c < 25; c++) begin
                b = 8'(rnd());
                tick();
                {bv, fn, ch, bi} = {1'b1, fl[i], 5'(c), b};
                eq_tx.push_back((c > 23 || cc[c % 24]) ? b : {b[7:1], rob(fl[i], act[c % 24], b[0])});
            end
        end
        tick();
        bv = 0;
    endtask : sweep

    // ****************************************
    // monitor and verdict
    // ****************************************
    task cmp(input string n, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : cmp

    always @(posedge ref_clk) rd_q <= mp_cs && mp_rd;

    // results are settled by the falling edge
    always @(negedge ref_clk) begin
        if (bov === 1'b1) cmp("tx_byte_out", eq_tx.pop_front(), bo);
        if (rd_q) cmp("mp_rdata", eq_rd.pop_front(), rdata);
    end

    task tally_and_finish();
        // a note never matched by a result means an output went missing
        if (eq_tx.size() != 0 || eq_rd.size() != 0) err_total++;
        if (err_total == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #300000;
        err_total++;
        tally_and_finish();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (4) tick();
        srst = 0;
        acc(0, PAGE_TX_LO, ADDR_SIG_BASE, 8'h00);
        for (int c = 0; c < 24; c++) begin
            w = 8'(rnd());
            regs[c] = w[3:0];
            acc(1, c < 16 ? PAGE_TX_LO : PAGE_TX_HI, ADDR_SIG_BASE + 5'(c % 16), w);
            acc(0, c < 16 ? PAGE_TX_LO : PAGE_TX_HI, ADDR_SIG_BASE + 5'(c % 16), {4'h0, w[3:0]});
        end
        acc(1, PAGE_TX_HI, 5'h18, 8'hFF);
        acc(0, PAGE_TX_HI, 5'h18, 8'h00);
        acc(0, PAGE_TX_HI, ADDR_SIG_BASE, {4'h0, regs[16]});
        sel = '1;
        cc = 24'(rnd());
        esf = 1;
        sf();
        sweep();
        esf = 0;
        sweep();
        regs[0] = ~regs[0];
        acc(1, PAGE_TX_LO, ADDR_SIG_BASE, {4'hF, regs[0]});
        sweep();
        sel = 24'(rnd());
        cc = 0;
        // the nibble is picked as a slot is captured, so every setting needs a fresh stream frame
        for (int n = 0; n < 4; n++) begin
            uns = n[0];
            esf = n[1];
            sbytes = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
            tick();
            go = 1;
            tick();
            go = 0;
            repeat (1200) tick();
            sf();
            sweep();
        end
        repeat (2) tick();
        tally_and_finish();
    end
endmodule : tsig_top_bench
